/* File: mix_slot_params.svh */
// register offsets, field positions, reset values and widths for the mix/slot block
`ifndef MIX_SLOT_PARAMS_SVH
`define MIX_SLOT_PARAMS_SVH
`define REG_IDX_MIX_CFG 4'hA
`define REG_IDX_CHAN1_SLOT_FIELD 4'hB
`define REG_IDX_CHAN2_SLOT_FIELD 4'hC
`define REG_IDX_CHAN3_SLOT_FIELD 4'hD
`define ADDR_LSB 2
`define ADDR_MSB 5
`define MIX_SEL_HI 7
`define MIX_SEL_LO 6
`define GAIN_SEL_HI 5
`define GAIN_SEL_LO 4
`define INVERT_BIT 3
`define SLOT_HI 5
`define SLOT_LO 0
`define MIX_SEL_RESET 2'h0
`define GAIN_SEL_RESET 2'h0
`define INVERT_RESET 1'h0
`define CHAN1_SLOT_FIELD_RESET 6'h00
`define CHAN2_SLOT_FIELD_RESET 6'h01
`define CHAN3_SLOT_FIELD_RESET 6'h02
`define SAMPLE_W 24
`define GAIN_SHIFT_M6 1
`define GAIN_SHIFT_M12 2
`define GAIN_SHIFT_M18 3
`define NUM_SLOT_CH 3
`endif

/* File: mix_slot_pkg.sv */
// types shared by the mix/slot block
package mix_slot_pkg;
  typedef enum logic [1:0] {
    MIX_NONE = 2'b00,
    MIX_CH1 = 2'b01,
    MIX_CH2 = 2'b10,
    MIX_BOTH = 2'b11
  } mix_sel_t;
  typedef enum logic [1:0] {
    GAIN_0DB = 2'b00,
    GAIN_M6DB = 2'b01,
    GAIN_M12DB = 2'b10,
    GAIN_M18DB = 2'b11
  } gain_sel_t;
endpackage : mix_slot_pkg

/* File: serial_input_mix_slot_map.sv */
// serial input mixing into channels 1 and 2 with slot assignment registers over apb
`timescale 1ns/1ps
`include "mix_slot_params.svh"
module serial_input_mix_slot_map
  import mix_slot_pkg::*;
#(
  parameter int SW = `SAMPLE_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample input: channel data and serial input pair
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [SW-1:0] chan1_in,
  input wire logic [SW-1:0] chan2_in,
  input wire logic [SW-1:0] serial_in1,
  input wire logic [SW-1:0] serial_in2,
  // mixed sample output with slot positions
  output logic out_valid,
  input wire logic out_ready,
  output logic [SW-1:0] chan1_out,
  output logic [SW-1:0] chan2_out,
  output logic [5:0] chan1_slot,
  output logic [5:0] chan2_slot,
  output logic [5:0] chan3_slot,
  output logic chan1_right,
  output logic chan2_right,
  output logic chan3_right
);

  typedef struct packed {
    // configuration
    mix_sel_t mix_sel;
    gain_sel_t gain_sel;
    logic input_invert;
    logic [5:0] chan1_slot_field;
    logic [5:0] chan2_slot_field;
    logic [5:0] chan3_slot_field;
    // apb answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // two-entry sample buffer
    logic [1:0][SW-1:0] buf_a;
    logic [1:0][SW-1:0] buf_b;
    logic [1:0] buf_full;
    logic rd_ptr;
    logic wr_ptr;
    // handshakes and output stage
    logic in_ready;
    logic out_valid;
    logic [SW-1:0] out_a;
    logic [SW-1:0] out_b;
  } state_t;

  state_t s_q;
  state_t s_d;
  localparam int NCH = `NUM_SLOT_CH;

  function automatic logic [SW-1:0] scale(input logic [SW-1:0] x, input gain_sel_t g,
                                          input logic inv);
    logic signed [SW-1:0] v;
    // each gain step is one bit of arithmetic shift, about 6 dB
    case (g)
      GAIN_M6DB: begin
        v = $signed(x) >>> `GAIN_SHIFT_M6;
      end
      GAIN_M12DB: begin
        v = $signed(x) >>> `GAIN_SHIFT_M12;
      end
      GAIN_M18DB: begin
        v = $signed(x) >>> `GAIN_SHIFT_M18;
      end
      default: begin
        v = $signed(x);
      end
    endcase
    if (inv) begin
      v = -v;
    end
    return v;
  endfunction : scale

  function automatic logic [SW-1:0] sat_add(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic signed [SW:0] sum;
    logic [SW-1:0] pos_full;
    logic [SW-1:0] neg_full;
    pos_full = {1'b0, {(SW-1){1'b1}}};
    neg_full = {1'b1, {(SW-1){1'b0}}};
    // one guard bit shows overflow; clamp instead of wrapping
    sum = $signed({a[SW-1], a}) + $signed({b[SW-1], b});
    if (sum[SW] && !sum[SW-1]) begin
      sat_add = neg_full;
    end else if (!sum[SW] && sum[SW-1]) begin
      sat_add = pos_full;
    end else begin
      sat_add = sum[SW-1:0];
    end
  endfunction : sat_add

  function automatic logic [31:0] mix_word(input mix_sel_t m, input gain_sel_t g,
                                           input logic inv);
    logic [31:0] w;
    // bits below the invert flag stay zero on reads
    w = 32'h0000_0000;
    w[`MIX_SEL_HI:`MIX_SEL_LO] = m;
    w[`GAIN_SEL_HI:`GAIN_SEL_LO] = g;
    w[`INVERT_BIT] = inv;
    return w;
  endfunction : mix_word

  logic [3:0] reg_idx;
  logic acc;
  logic addr_ok;
  logic hit_mix;
  logic hit_ch1;
  logic hit_ch2;
  logic hit_ch3;
  logic wr_en;
  logic in_fire;
  logic out_fire;
  logic add_a;
  logic add_b;
  logic [SW-1:0] in1s;
  logic [SW-1:0] in2s;
  logic [SW-1:0] src_b;
  logic [SW-1:0] mix_a;
  logic [SW-1:0] mix_b;
  logic [NCH-1:0][5:0] slot_vec;
  logic [NCH-1:0] right_vec;
  logic [NCH-1:0][31:0] slot_word;

  assign reg_idx = paddr[`ADDR_MSB:`ADDR_LSB];
  // one access per transfer: the registered pready closes the access phase
  assign acc = psel && penable && !s_q.pready;
  // bits above the register window and the byte offset must be zero for a hit
  assign addr_ok = (paddr[11:`ADDR_MSB+1] == '0) && (paddr[`ADDR_LSB-1:0] == '0);
  assign hit_mix = addr_ok && (reg_idx == `REG_IDX_MIX_CFG);
  assign hit_ch1 = addr_ok && (reg_idx == `REG_IDX_CHAN1_SLOT_FIELD);
  assign hit_ch2 = addr_ok && (reg_idx == `REG_IDX_CHAN2_SLOT_FIELD);
  assign hit_ch3 = addr_ok && (reg_idx == `REG_IDX_CHAN3_SLOT_FIELD);
  // only the low byte lane carries register bits
  assign wr_en = pwrite && pstrb[0];
  assign in_fire = in_valid && s_q.in_ready;
  assign out_fire = s_q.out_valid && out_ready;

  // per-channel slot fields; values 32 and up address the right half-frame
  assign slot_vec = {s_q.chan3_slot_field, s_q.chan2_slot_field, s_q.chan1_slot_field};
  for (genvar n = 0; n < NCH; n++) begin : g_slot
    assign right_vec[n] = slot_vec[n][`SLOT_HI];
    assign slot_word[n] = 32'(slot_vec[n]);
  end

  always_comb begin
    // input samples are scaled and optionally negated before the add
    in1s = scale(serial_in1, s_q.gain_sel, s_q.input_invert);
    in2s = scale(serial_in2, s_q.gain_sel, s_q.input_invert);
    add_a = 1'b0;
    add_b = 1'b0;
    src_b = in1s;
    case (s_q.mix_sel)
      MIX_CH1: begin
        add_a = 1'b1;
      end
      MIX_CH2: begin
        add_b = 1'b1;
      end
      MIX_BOTH: begin
        add_a = 1'b1;
        add_b = 1'b1;
        src_b = in2s;
      end
      default: begin
        add_a = 1'b0;
      end
    endcase
    mix_a = add_a ? sat_add(chan1_in, in1s) : chan1_in;
    mix_b = add_b ? sat_add(chan2_in, src_b) : chan2_in;
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = acc;
    s_d.pslverr = 1'b0;
    if (acc) begin
      s_d.prdata = 32'h0000_0000;
      if (!addr_ok) begin
        s_d.pslverr = 1'b1;
      end else if (hit_mix) begin
        s_d.prdata = mix_word(s_q.mix_sel, s_q.gain_sel, s_q.input_invert);
        if (wr_en) begin
          s_d.mix_sel = mix_sel_t'(pwdata[`MIX_SEL_HI:`MIX_SEL_LO]);
          s_d.gain_sel = gain_sel_t'(pwdata[`GAIN_SEL_HI:`GAIN_SEL_LO]);
          s_d.input_invert = pwdata[`INVERT_BIT];
        end
      end else if (hit_ch1) begin
        s_d.prdata = slot_word[0];
        if (wr_en) begin
          s_d.chan1_slot_field = pwdata[`SLOT_HI:`SLOT_LO];
        end
      end else if (hit_ch2) begin
        s_d.prdata = slot_word[1];
        if (wr_en) begin
          s_d.chan2_slot_field = pwdata[`SLOT_HI:`SLOT_LO];
        end
      end else if (hit_ch3) begin
        s_d.prdata = slot_word[2];
        if (wr_en) begin
          s_d.chan3_slot_field = pwdata[`SLOT_HI:`SLOT_LO];
        end
      end else begin
        // unmapped register inside the window
        s_d.pslverr = 1'b1;
      end
    end

    // two-entry buffer: mixed samples in, output register drains it
    if (in_fire) begin
      s_d.buf_a[s_q.wr_ptr] = mix_a;
      s_d.buf_b[s_q.wr_ptr] = mix_b;
      s_d.buf_full[s_q.wr_ptr] = 1'b1;
      s_d.wr_ptr = !s_q.wr_ptr;
    end
    if (out_fire || !s_q.out_valid) begin
      s_d.out_valid = 1'b0;
      if (s_q.buf_full[s_q.rd_ptr]) begin
        s_d.out_a = s_q.buf_a[s_q.rd_ptr];
        s_d.out_b = s_q.buf_b[s_q.rd_ptr];
        s_d.out_valid = 1'b1;
        s_d.buf_full[s_q.rd_ptr] = 1'b0;
        s_d.rd_ptr = !s_q.rd_ptr;
      end
    end

    // ready looks at the entry that the next write will use
    s_d.in_ready = !s_d.buf_full[s_d.wr_ptr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.prdata <= '0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.buf_a <= '0;
      s_q.buf_b <= '0;
      s_q.buf_full <= '0;
      s_q.rd_ptr <= 1'b0;
      s_q.wr_ptr <= 1'b0;
      s_q.out_valid <= 1'b0;
      s_q.out_a <= '0;
      s_q.out_b <= '0;
      // configuration fields take their reset defaults
      s_q.mix_sel <= mix_sel_t'(`MIX_SEL_RESET);
      s_q.gain_sel <= gain_sel_t'(`GAIN_SEL_RESET);
      s_q.input_invert <= `INVERT_RESET;
      s_q.chan1_slot_field <= `CHAN1_SLOT_FIELD_RESET;
      s_q.chan2_slot_field <= `CHAN2_SLOT_FIELD_RESET;
      s_q.chan3_slot_field <= `CHAN3_SLOT_FIELD_RESET;
      s_q.in_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // every output below is a flip-flop of the state
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign in_ready = s_q.in_ready;
  assign out_valid = s_q.out_valid;
  assign chan1_out = s_q.out_a;
  assign chan2_out = s_q.out_b;
  assign chan1_slot = s_q.chan1_slot_field;
  assign chan2_slot = s_q.chan2_slot_field;
  assign chan3_slot = s_q.chan3_slot_field;
  assign chan1_right = right_vec[0];
  assign chan2_right = right_vec[1];
  assign chan3_right = right_vec[2];

endmodule : serial_input_mix_slot_map

/* File: mix_slot_monitor.sv */
// concurrent checks on the mix and slot block ports
`timescale 1ns/1ps
module mix_slot_monitor #(parameter int SW = 24) (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic in_valid, in_ready, out_valid, out_ready,
  input wire logic [SW-1:0] chan1_out, chan2_out,
  input wire logic [5:0] chan1_slot, chan2_slot,
  input wire logic chan1_right, chan2_right
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite && !pslverr;
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_bad_addr: assert property (pready && paddr == 12'h038 |-> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  a_mix_rsvd: assert property (rd && paddr == 12'h028 |-> prdata[2:0] == 3'h0)
    else $error("mix reserved set");
  a_slot_rsvd: assert property (rd && paddr[5:2] > 4'hA |-> prdata[31:6] == 26'h0)
    else $error("slot reserved set");
  a_slot_read: assert property (rd && paddr == 12'h02C |-> prdata[5:0] == chan1_slot)
    else $error("slot readback");
  a_right_half: assert property (chan1_right == chan1_slot[5] && chan2_right == chan2_slot[5])
    else $error("right half");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(chan1_out)
    && $stable(chan2_out)) else $error("output dropped");
  a_take_out: assert property (in_valid && in_ready && !out_valid |=> ##1 out_valid)
    else $error("output late");
  c_write: cover property (pready && pwrite);
  c_stall: cover property (out_valid && !out_ready);
  c_full: cover property (in_valid && !in_ready);
endmodule : mix_slot_monitor
bind serial_input_mix_slot_map mix_slot_monitor #(.SW(SW)) mix_slot_monitor_i (.*);

/* File: sample_sink_model.sv */
// far-side sample sink: always ready, every other cycle, or stalled
`timescale 1ns/1ps
module sample_sink_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  output logic out_ready
);
  logic tog_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tog_q <= 1'h0;
    else tog_q <= !tog_q;
  end
  assign out_ready = mode == 2'h0 || (mode == 2'h1 && tog_q);
endmodule : sample_sink_model

/* File: serial_input_mix_slot_map_tb_top.sv */
// bench: registers over apb, mixed samples through the buffer
`timescale 1ns/1ps
`include "mix_slot_params.svh"
module serial_input_mix_slot_map_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, ci = 0;
  logic pready, pslverr, in_ready, out_valid, out_ready, chan1_right, chan2_right, chan3_right;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [32:0] rd;
  logic [3:0] pstrb = 4'hF;
  logic [23:0] chan1_in = 0, chan2_in = 0, serial_in1 = 0, serial_in2 = 0, chan1_out, chan2_out;
  logic [5:0] chan1_slot, chan2_slot, chan3_slot;
  logic [1:0] cm = 0, cg = 0, smode = 0;
  logic [47:0] expq[$];
  int n_mismatch = 0, n_tests = 0;
  always #4 pclk = ~pclk;
  serial_input_mix_slot_map serial_input_mix_slot_map_i (.*);
  sample_sink_model sample_sink_model_i (.pclk(pclk), .presetn(presetn), .mode(smode),
    .out_ready(out_ready));
  task automatic chk(input logic [47:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("mismatches %0d of %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic await(ref logic s);
    int i = 0;
    do @(posedge pclk); while (s !== 1'h1 && ++i < 50);
    if (i == 50) begin
      n_mismatch++;
      results();
    end
  endtask : await
  task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {6'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    await(pready);
    rd = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [23:0] add(input logic [23:0] c, s);
    logic [23:0] t;
    logic [24:0] r;
    t = $signed(s) >>> cg;
    if (ci) t = -t;
    r = {c[23], c} + {t[23], t};
    return (r[24] != r[23]) ? {r[24], {23{!r[24]}}} : r[23:0];
  endfunction : add
  function automatic logic [47:0] exp48();
    return {cm[0] ? add(chan1_in, serial_in1) : chan1_in, cm == 2'h2 ?
      add(chan2_in, serial_in1) : cm == 2'h3 ? add(chan2_in, serial_in2) : chan2_in};
  endfunction : exp48
  task automatic push(input logic [23:0] a, b, x, y);
    chan1_in <= a;
    chan2_in <= b;
    serial_in1 <= x;
    serial_in2 <= y;
    in_valid <= 1'h1;
    await(in_ready);
    expq.push_back(exp48());
    in_valid <= 1'h0;
  endtask : push
  always @(posedge pclk) begin
    if (out_valid === 1'h1 && out_ready === 1'h1) chk({chan1_out, chan2_out}, expq.pop_front());
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      apb(1'h0, 4'(`REG_IDX_MIX_CFG + k), 32'h0);
      chk(rd, k == 0 ? 0 : k - 1);
    end
    for (int k = 1; k < 4; k++) begin
      apb(1'h1, 4'(`REG_IDX_MIX_CFG + k), 32'h3F);
      apb(1'h0, 4'(`REG_IDX_MIX_CFG + k), 32'h0);
      chk(rd, 33'h3F);
    end
    chk({chan1_slot, chan2_slot, chan3_slot, chan1_right, chan2_right, chan3_right}, 21'h1FFFFF);
    apb(1'h1, `REG_IDX_CHAN1_SLOT_FIELD, 32'h1F);
    apb(1'h1, `REG_IDX_CHAN2_SLOT_FIELD, 32'h20);
    chk({chan1_slot, chan1_right, chan2_slot, chan2_right}, {6'h1F, 1'h0, 6'h20, 1'h1});
    apb(1'h1, `REG_IDX_MIX_CFG, 32'hF8);
    apb(1'h0, `REG_IDX_MIX_CFG, 32'h0);
    chk(rd, 33'hF8);
    apb(1'h0, 4'hE, 32'h0);
    chk(rd, 33'h100000000);
    smode <= 2'h1;
    for (int k = 0; k < 17; k++) begin
      {cm, cg, ci} = k < 16 ? {2'(k >> 2), 2'(k), k[0]} : 5'h18;
      apb(1'h1, `REG_IDX_MIX_CFG, {24'h0, cm, cg, ci, 3'h0});
      if (k < 16) push(24'h100000, 24'hF00000, 24'h040000, 24'hFC0000);
      else push(24'h7FFFF0, 24'h800010, 24'h000100, 24'hFFFF00);
    end
    smode <= 2'h2;
    @(posedge pclk);
    in_valid <= 1'h1;
    for (int j = 0; j < 8; j++) begin
      @(posedge pclk);
      if (in_ready === 1'h1) expq.push_back(exp48());
    end
    chk(in_ready, 1'h0);
    in_valid <= 1'h0;
    smode <= 2'h0;
    for (int j = 0; j < 50 && expq.size() > 0; j++) @(posedge pclk);
    chk(expq.size(), 0);
    results();
  end
endmodule : serial_input_mix_slot_map_tb_top
